/* File: hw/stc_consts.svh */
// constants for the stepper translator and stall control block
// assumes a 100 MHz ref_clk and word-aligned AHB-Lite register access
`ifndef STC_CONSTS_SVH
`define STC_CONSTS_SVH
`define STC_CLK_MHZ      100
`define STC_A_CTRL       5'h00
`define STC_A_POS        5'h04
`define STC_A_STALL      5'h08
`define STC_A_STATUS     5'h0C
`define STC_A_BEMF       5'h10
`define STC_B_EN         0
`define STC_B_INV        1
`define STC_B_SOFT       2
`define STC_F_RES        5:3
`define STC_B_FILT       6
`define STC_B_BOOST      7
`define STC_F_PEAK       11:8
`define STC_F_UVSEL      13:12
`define STC_B_UVACT      14
`define STC_B_STRM       15
`define STC_F_TO         7:0
`define STC_F_THR        11:8
`define STC_F_LIM        23:16
`define STC_RES_RST      3'h0
`define STC_POS_RST      6'h08
`define STC_PEAK_RST     4'h0
`define STC_RES_FULL     3'h4
`define STC_STALL_BACK   6'h18
`define STC_UV_T0_US     5
`define STC_UV_T1_US     10
`define STC_UV_T2_US     20
`define STC_UV_T3_US     40
`define STC_PWM_US       50
`define STC_SPD_UNIT_US  20
`endif

/* File: hw/stc_pkg.sv */
// types of the stepper translator and stall control block
// assumes stc_consts.svh carries the register map, field, reset and timing constants
package stc_pkg;
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_DATA = 2'b10
	} stc_bus_e;
	typedef logic [5:0] stc_pos_t;
endpackage

/* File: hw/stc_top.sv */
// stepper translator, step triggers, low supply handling, back-emf and stall control
// assumes an AHB-Lite master, analog front end on ref_clk, pins asynchronous
// What this block does
// RL1: direction is pin xor invert bit
// RL2: disabled drive still steps unless filter set
// RL3: pin rise or soft step moves one step
// RL4: soft step bit self-clears after stepping
// RL5: separated pin and soft steps both count
// RL6: new resolution applies at next trigger only
// RL7: one write: step uses new settings
// RL8: position write applies at once
// RL9: thermal warning drops boost, boost readable
// RL10: peak code selects sixteen current levels
// RL11: peak code applied at next pwm period
// RL12: sleep ignores step and direction pins
// RL13: low supply warning set, read clears after
// RL14: debounced low supply sets fault, error out
// RL15: enable write accepted only without fault
// RL16: fault action bit: hi-z or brake
// RL17: trigger during low supply sets lost step
// RL18: back-emf code, ready, normal or streaming
// RL19: timeout in units of four pwm periods, zero off
// RL20: two low crossings: stall, back 135 degrees
// RL21: stall clears on read after direction toggle
// RL22: measure only when interval within limit
// RL23: resolution codes sixteenth to full step
// RL24: reduced resolution rounds toward rotation
// RL25: position wraps modulo 64 by stride
`timescale 1ns/1ns
`include "stc_consts.svh"
`default_nettype none
module stc_top #(
	parameter int PWM_CYC = `STC_PWM_US * `STC_CLK_MHZ,
	parameter int SPD_CYC = `STC_SPD_UNIT_US * `STC_CLK_MHZ
) (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        step_pulse_pin,
	input  wire logic        dir_pin,
	input  wire logic        uv_comp,
	input  wire logic        thermal_warn,
	input  wire logic        sleep_mode,
	input  wire logic        zc_active,
	input  wire logic        bemf_valid,
	input  wire logic [4:0]  bemf_code,
	output logic      [5:0]  translator_position,
	output logic             rotation_up,
	output logic      [3:0]  peak_current_code,
	output logic             boost_applied,
	output logic             bridge_hiz,
	output logic             bridge_brake,
	output logic             fault_out_n_o,
	output logic             fault_out_n_oe
);
	function automatic logic [5:0] stc_mask(input logic [2:0] r);
		logic [2:0] rr;
		rr = (r > `STC_RES_FULL) ? `STC_RES_FULL : r;
		stc_mask = (6'h01 << rr) - 6'h01;
	endfunction
	function automatic logic [5:0] stc_next(input logic [5:0] p, input logic [2:0] r,
		input logic up);
		logic [5:0] m;
		logic [5:0] b;
		m = stc_mask(r);
		b = p & ~m;
		if (up) begin
			stc_next = b + m + 6'h01;
		end else begin
			stc_next = ((p & m) != 6'h00) ? b : b - m - 6'h01;
		end
	endfunction

	stc_pkg::stc_bus_e bus_ff, nxt_bus;
	logic [4:0]  adr_ff;
	logic        wr_ff;
	logic [31:0] hrdata_ff;
	logic        hready_ff;
	logic        hresp_ff;
	logic [2:0]  stp_s_ff, dir_s_ff;
	logic [1:0]  uv_s_ff, tw_s_ff;
	logic        dir_live_ff, up_ff;
	logic        en_ff, inv_ff, soft_ff, filt_ff, boost_ff, uvact_ff, strm_ff;
	logic [2:0]  res_ff;
	logic [3:0]  peak_ff, peak_out_ff;
	logic [1:0]  uvsel_ff;
	logic [7:0]  to_ff, lim_ff, spd_ff;
	logic [3:0]  thr_ff;
	stc_pkg::stc_pos_t pos_ff, nxt_pos;
	logic        boost_out_ff, hiz_ff, brake_ff, foe_ff, fo_ff;
	logic        uvw_ff, uvf_ff, lost_ff, stall_ff, tog_ff, rdy_ff;
	logic [11:0] uvc_ff;
	logic [15:0] pwm_ff, spc_ff;
	logic [9:0]  toc_ff;
	logic        zcp_ff, tod_ff;
	logic [4:0]  last_ff, bemf_ff;
	logic [1:0]  low_ff;

	// bus decode
	wire acc      = hsel & htrans[1] & hready;
	wire dph      = (bus_ff == stc_pkg::BUS_DATA);
	wire wr_now   = dph & wr_ff;
	wire rd_now   = dph & ~wr_ff;
	wire ctrl_wr  = wr_now & (adr_ff == `STC_A_CTRL);
	wire pos_wr   = wr_now & (adr_ff == `STC_A_POS);
	wire stl_wr   = wr_now & (adr_ff == `STC_A_STALL);
	wire st_rd    = rd_now & (adr_ff == `STC_A_STATUS);
	wire bemf_rd  = rd_now & (adr_ff == `STC_A_BEMF);
	assign nxt_bus = acc & ~dph ? stc_pkg::BUS_DATA : stc_pkg::BUS_IDLE;

	// step trigger and direction
	wire pin_rise = stp_s_ff[1] & ~stp_s_ff[2] & ~sleep_mode; // [RL12]
	wire allow    = ~(filt_ff & ~en_ff) & ~sleep_mode; // [RL2]
	wire trig     = (pin_rise | soft_ff) & allow; // [RL3] [RL5]
	wire step_go  = trig & ~stall_ff; // [RL21]
	wire eff_up   = dir_live_ff ^ inv_ff; // [RL1]
	wire uv_any   = uv_s_ff[1] | uvf_ff;
	wire pwm_tick = (pwm_ff == 16'(PWM_CYC - 1));
	wire spd_tick = (spc_ff == 16'(SPD_CYC - 1));

	// back-emf and stall
	wire meas_en  = (spd_ff <= lim_ff); // [RL22]
	wire to_hit   = zc_active & ~tod_ff & (to_ff != 8'h00) & (toc_ff == {to_ff, 2'b00}); // [RL19]
	wire zc_end   = meas_en & ((zcp_ff & ~zc_active & ~tod_ff) | to_hit);
	wire below    = (last_ff[4:1] < thr_ff); // [RL20]
	wire chk      = zc_end & (thr_ff != 4'h0);
	wire stall_ev = chk & below & (low_ff == 2'h1) & ~stall_ff; // [RL20]
	wire take     = bemf_valid & zc_active & meas_en;
	wire [4:0] pub = strm_ff & take ? bemf_code : last_ff; // [RL18]
	wire pub_ev   = (strm_ff & take) | zc_end;

	wire [11:0] uv_lim = (uvsel_ff == 2'h0) ? 12'(`STC_UV_T0_US * `STC_CLK_MHZ) :
		(uvsel_ff == 2'h1) ? 12'(`STC_UV_T1_US * `STC_CLK_MHZ) :
		(uvsel_ff == 2'h2) ? 12'(`STC_UV_T2_US * `STC_CLK_MHZ) :
		12'(`STC_UV_T3_US * `STC_CLK_MHZ); // [RL14]
	wire [5:0] back_pos = eff_up ? pos_ff - `STC_STALL_BACK : pos_ff + `STC_STALL_BACK;
	assign nxt_pos = pos_wr ? hwdata[5:0] : // [RL8]
		stall_ev ? back_pos : // [RL20]
		step_go ? stc_next(pos_ff, res_ff, eff_up) : pos_ff; // [RL6] [RL7] [RL23] [RL24] [RL25]

	wire [31:0] r_ctrl = {16'h0000, strm_ff, uvact_ff, uvsel_ff, peak_ff, boost_ff,
		filt_ff, res_ff, soft_ff, inv_ff, en_ff};
	wire [31:0] r_stl  = {8'h00, lim_ff, 4'h0, thr_ff, to_ff};
	wire [31:0] r_st   = {25'h000_0000, en_ff, dir_live_ff, boost_ff, stall_ff,
		lost_ff, uvf_ff, uvw_ff}; // [RL9]
	wire [31:0] r_bemf = {16'h0000, spd_ff, 2'h0, rdy_ff, bemf_ff};
	wire [31:0] rdata  = (adr_ff == `STC_A_CTRL) ? r_ctrl :
		(adr_ff == `STC_A_POS) ? {26'h000_0000, pos_ff} :
		(adr_ff == `STC_A_STALL) ? r_stl :
		(adr_ff == `STC_A_STATUS) ? r_st :
		(adr_ff == `STC_A_BEMF) ? r_bemf : 32'h0000_0000;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			bus_ff <= stc_pkg::BUS_IDLE;
			adr_ff <= 5'h00;
			wr_ff <= 1'b0;
			hready_ff <= 1'b1;
			hrdata_ff <= 32'h0000_0000;
			hresp_ff <= 1'b0;
		end else begin
			bus_ff <= nxt_bus;
			if (acc & ~dph) begin
				adr_ff <= {haddr[4:2], 2'b00};
				wr_ff <= hwrite;
			end
			hready_ff <= ~(acc & ~dph);
			if (rd_now) begin
				hrdata_ff <= rdata;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			stp_s_ff <= 3'h0;
			dir_s_ff <= 3'h0;
			uv_s_ff <= 2'h0;
			tw_s_ff <= 2'h0;
		end else begin
			stp_s_ff <= {stp_s_ff[1:0], step_pulse_pin};
			dir_s_ff <= {dir_s_ff[1:0], dir_pin};
			uv_s_ff <= {uv_s_ff[0], uv_comp};
			tw_s_ff <= {tw_s_ff[0], thermal_warn};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			dir_live_ff <= 1'b0;
			up_ff <= 1'b0;
		end else begin
			if (~sleep_mode) begin
				dir_live_ff <= dir_s_ff[2]; // [RL12]
			end
			up_ff <= eff_up;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			en_ff <= 1'b0;
			inv_ff <= 1'b0;
			soft_ff <= 1'b0;
			res_ff <= `STC_RES_RST;
			filt_ff <= 1'b0;
			boost_ff <= 1'b0;
			peak_ff <= `STC_PEAK_RST;
			uvsel_ff <= 2'h0;
			uvact_ff <= 1'b0;
			strm_ff <= 1'b0;
		end else begin
			soft_ff <= ctrl_wr & hwdata[`STC_B_SOFT]; // [RL4] [RL7]
			if (ctrl_wr) begin
				en_ff <= hwdata[`STC_B_EN] & ~uvf_ff; // [RL15]
				inv_ff <= hwdata[`STC_B_INV];
				res_ff <= hwdata[`STC_F_RES];
				filt_ff <= hwdata[`STC_B_FILT];
				peak_ff <= hwdata[`STC_F_PEAK]; // [RL10]
				uvsel_ff <= hwdata[`STC_F_UVSEL];
				uvact_ff <= hwdata[`STC_B_UVACT];
				strm_ff <= hwdata[`STC_B_STRM];
			end else if (uvf_ff) begin
				en_ff <= 1'b0;
			end
			boost_ff <= tw_s_ff[1] ? 1'b0 : ctrl_wr ? hwdata[`STC_B_BOOST] : boost_ff; // [RL9]
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			to_ff <= 8'h00;
			thr_ff <= 4'h0;
			lim_ff <= 8'h00;
		end else if (stl_wr) begin
			to_ff <= hwdata[`STC_F_TO];
			thr_ff <= hwdata[`STC_F_THR];
			lim_ff <= hwdata[`STC_F_LIM];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pos_ff <= `STC_POS_RST;
		end else begin
			pos_ff <= nxt_pos;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pwm_ff <= 16'h0000;
			spc_ff <= 16'h0000;
			spd_ff <= 8'hFF;
			peak_out_ff <= `STC_PEAK_RST;
			boost_out_ff <= 1'b0;
		end else begin
			pwm_ff <= pwm_tick ? 16'h0000 : pwm_ff + 16'h0001;
			spc_ff <= (spd_tick | step_go) ? 16'h0000 : spc_ff + 16'h0001;
			if (step_go) begin
				spd_ff <= 8'h00;
			end else if (spd_tick & (spd_ff != 8'hFF)) begin
				spd_ff <= spd_ff + 8'h01;
			end
			if (pwm_tick) begin
				peak_out_ff <= peak_ff; // [RL11]
				boost_out_ff <= boost_ff & ~tw_s_ff[1];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			uvw_ff <= 1'b0;
			uvf_ff <= 1'b0;
			uvc_ff <= 12'h000;
			lost_ff <= 1'b0;
		end else begin
			uvw_ff <= uv_s_ff[1] | (uvw_ff & ~st_rd); // [RL13]
			uvc_ff <= ~uv_s_ff[1] ? 12'h000 : (uvc_ff == uv_lim) ? uvc_ff : uvc_ff + 12'h001;
			uvf_ff <= (uvc_ff == uv_lim) | (uvf_ff & ~(st_rd & ~uv_s_ff[1])); // [RL14]
			lost_ff <= ((trig | pos_wr) & uv_any) | (lost_ff & ~st_rd); // [RL17]
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			zcp_ff <= 1'b0;
			tod_ff <= 1'b0;
			toc_ff <= 10'h000;
			last_ff <= 5'h00;
			bemf_ff <= 5'h00;
			rdy_ff <= 1'b0;
		end else begin
			zcp_ff <= zc_active;
			tod_ff <= zc_active & (tod_ff | to_hit);
			toc_ff <= ~zc_active ? 10'h000 : pwm_tick ? toc_ff + 10'h001 : toc_ff;
			if (take) begin
				last_ff <= bemf_code;
			end
			if (pub_ev) begin
				bemf_ff <= pub; // [RL18]
			end
			rdy_ff <= pub_ev | (rdy_ff & ~bemf_rd);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			low_ff <= 2'h0;
			stall_ff <= 1'b0;
			tog_ff <= 1'b0;
		end else begin
			if (chk) begin
				low_ff <= (below & ~stall_ff & (low_ff == 2'h0)) ? 2'h1 : 2'h0;
			end
			stall_ff <= stall_ev | (stall_ff & ~(st_rd & tog_ff)); // [RL21]
			tog_ff <= stall_ff & (tog_ff | (eff_up != up_ff));
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			hiz_ff <= 1'b1;
			brake_ff <= 1'b0;
			foe_ff <= 1'b0;
			fo_ff <= 1'b0;
		end else begin
			brake_ff <= uvf_ff & uvact_ff; // [RL16]
			hiz_ff <= ~(uvf_ff & uvact_ff) & (uvf_ff | ~en_ff);
			foe_ff <= ~sleep_mode & (uvf_ff | stall_ff); // [RL14] [RL21]
			fo_ff <= 1'b0;
		end
	end

	assign hrdata = hrdata_ff;
	assign hreadyout = hready_ff;
	assign hresp = hresp_ff;
	assign translator_position = pos_ff;
	assign rotation_up = up_ff;
	assign peak_current_code = peak_out_ff;
	assign boost_applied = boost_out_ff;
	assign bridge_hiz = hiz_ff;
	assign bridge_brake = brake_ff;
	assign fault_out_n_o = fo_ff;
	assign fault_out_n_oe = foe_ff;

	property p_soft;
		@(posedge ref_clk) disable iff (reset) soft_ff |=> !soft_ff;
	endproperty
	a_soft: assert property (p_soft) else $error("soft step not cleared"); // [RL4]
	property p_hold;
		@(posedge ref_clk) disable iff (reset) !trig && !pos_wr && !stall_ev |=> $stable(pos_ff);
	endproperty
	a_hold: assert property (p_hold) else $error("position moved without trigger"); // [RL6]
	property p_step;
		@(posedge ref_clk) disable iff (reset)
			step_go && !pos_wr && !stall_ev |=> (pos_ff & stc_mask($past(res_ff))) == 6'h00;
	endproperty
	a_step: assert property (p_step) else $error("step not on stride"); // [RL24]
	property p_poswr;
		@(posedge ref_clk) disable iff (reset) pos_wr |=> pos_ff == $past(hwdata[5:0]);
	endproperty
	a_poswr: assert property (p_poswr) else $error("position write lost"); // [RL8]
	property p_lost;
		@(posedge ref_clk) disable iff (reset) trig && uv_s_ff[1] |=> lost_ff;
	endproperty
	a_lost: assert property (p_lost) else $error("lost step not flagged"); // [RL17]
	property p_en;
		@(posedge ref_clk) disable iff (reset) ctrl_wr && uvf_ff |=> !en_ff;
	endproperty
	a_en: assert property (p_en) else $error("enable taken during fault"); // [RL15]
	property p_err;
		@(posedge ref_clk) disable iff (reset) stall_ff && !sleep_mode |=> fault_out_n_oe;
	endproperty
	a_err: assert property (p_err) else $error("error output idle in stall"); // [RL21]
	property p_peak;
		@(posedge ref_clk) disable iff (reset)
			!pwm_tick ##1 !pwm_tick |-> $stable(peak_current_code);
	endproperty
	a_peak: assert property (p_peak) else $error("peak changed mid period"); // [RL11]
	property p_boost;
		@(posedge ref_clk) disable iff (reset) tw_s_ff[1] |=> !boost_ff ##1 !boost_ff;
	endproperty
	a_boost: assert property (p_boost) else $error("boost kept at warning"); // [RL9]
	property p_uvw;
		@(posedge ref_clk) disable iff (reset) uv_s_ff[1] |=> uvw_ff;
	endproperty
	a_uvw: assert property (p_uvw) else $error("warning not set"); // [RL13]
endmodule // stc_top
`default_nettype wire

/* File: verif/stc_mcu_model.sv */
// far-side microcontroller model driving the step pulse and direction pins
// assumes a free running link_clk and a step request count from the bench
`timescale 1ns/1ns
`default_nettype none
module stc_mcu_model (
	input  wire logic       link_clk,
	input  wire logic [7:0] step_req,
	input  wire logic       dir_req,
	output logic            step_pulse_pin,
	output logic            dir_pin
);
	logic [7:0] done_ff;
	initial begin
		step_pulse_pin = 1'b0;
		dir_pin = 1'b0;
		done_ff = 8'h00;
	end
	// direction moves a link cycle apart from pulses, one pulse per request
	always @(posedge link_clk) begin
		if (step_pulse_pin) begin
			step_pulse_pin <= 1'b0;
		end else if (done_ff != step_req) begin
			step_pulse_pin <= 1'b1;
			done_ff <= done_ff + 8'h01;
		end else begin
			dir_pin <= dir_req;
		end
	end
endmodule // stc_mcu_model
`default_nettype wire

/* File: verif/test_stepper_translator_stall_control.sv */
// testbench: steps, resolution, position writes, low supply, sleep, current code
// assumes stc_top with short pwm and interval parameters and an AHB-Lite master here
`timescale 1ns/1ns
`include "stc_consts.svh"
`default_nettype none
module test_stepper_translator_stall_control;
	logic ref_clk, reset, hsel, hwrite, link_clk, dir_req, uv_comp, thermal_warn, sleep_mode;
	logic [31:0] haddr, hwdata, hrdata, ctrl, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic hreadyout, hresp, step_pulse_pin, dir_pin, rotation_up, boost_applied;
	logic bridge_hiz, bridge_brake, fault_out_n_o, fault_out_n_oe;
	logic [5:0] translator_position;
	logic [3:0] peak_current_code;
	logic [7:0] step_req;
	logic zc_active, bemf_valid;
	logic [4:0] bemf_code;
	stc_pkg::stc_pos_t exp_pos;
	int bad_count, total_checks, cycles;
	stc_top #(.PWM_CYC(20), .SPD_CYC(10)) i_dut (.ref_clk(ref_clk), .reset(reset), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.step_pulse_pin(step_pulse_pin), .dir_pin(dir_pin), .uv_comp(uv_comp),
		.thermal_warn(thermal_warn), .sleep_mode(sleep_mode), .zc_active(zc_active),
		.bemf_valid(bemf_valid), .bemf_code(bemf_code),
		.translator_position(translator_position),
		.rotation_up(rotation_up), .peak_current_code(peak_current_code),
		.boost_applied(boost_applied), .bridge_hiz(bridge_hiz), .bridge_brake(bridge_brake),
		.fault_out_n_o(fault_out_n_o), .fault_out_n_oe(fault_out_n_oe));
	stc_mcu_model i_mcu (.link_clk(link_clk), .step_req(step_req), .dir_req(dir_req),
		.step_pulse_pin(step_pulse_pin), .dir_pin(dir_pin));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	initial begin
		link_clk = 1'b0;
		forever begin
			#62 link_clk = 1'b1;
			#63 link_clk = 1'b0;
		end
	end
	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 30000) begin
			bad_count++;
			finish_test();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk(32'(hresp), 32'h0000_0000, "response");
	endtask
	task automatic wr_ctrl;
		bus(1'b1, 32'(`STC_A_CTRL), ctrl);
		idle(4);
	endtask
	task automatic pin_step(input logic moves);
		step_req <= step_req + 8'h01;
		idle(50);
		chk(32'(translator_position), 32'(exp_pos), moves ? "pin step" : "blocked step");
	endtask
	task automatic zc(input logic [4:0] code, input int len);
		zc_active <= 1'b1;
		bemf_valid <= 1'b1;
		bemf_code <= code;
		idle(1);
		bemf_valid <= 1'b0;
		idle(len);
		bus(1'b0, 32'(`STC_A_BEMF), 32'h0);
		zc_active <= 1'b0;
		idle(3);
	endtask
	task automatic t_reset;
		chk(32'(translator_position), 32'h0000_0008, "reset position");
		chk(32'({bridge_hiz, bridge_brake, fault_out_n_oe}), 32'h0000_0004, "reset bridge");
		bus(1'b0, 32'(`STC_A_POS), 32'h0);
		chk(rd & 32'h0000_003F, 32'h0000_0008, "position read");
		bus(1'b1, 32'h0000_001C, 32'hFFFF_FFFF);
		bus(1'b0, 32'h0000_0014, 32'h0);
		chk(rd, 32'h0000_0000, "unmapped read");
		$display("test reset finished");
	endtask
	task automatic t_dir;
		logic d, v;
		for (int i = 0; i < 4; i++) begin
			{v, d} = 2'(i);
			ctrl[`STC_B_INV] = v;
			dir_req <= d;
			wr_ctrl();
			idle(30);
			chk(32'(rotation_up), 32'(d ^ v), "direction");
			exp_pos = (d ^ v) ? exp_pos + 6'h01 : exp_pos - 6'h01;
			pin_step(1'b1);
		end
		ctrl[`STC_B_FILT] = 1'b1;
		wr_ctrl();
		pin_step(1'b0);
		ctrl[`STC_B_FILT] = 1'b0;
		$display("test direction finished");
	endtask
	task automatic t_res;
		ctrl[`STC_B_INV] = 1'b0;
		dir_req <= 1'b1;
		ctrl[`STC_F_RES] = 3'h3;
		wr_ctrl();
		idle(30);
		chk(32'(translator_position), 32'(exp_pos), "resolution alone");
		exp_pos = 6'h10;
		pin_step(1'b1);
		ctrl[`STC_F_RES] = 3'h4;
		ctrl[`STC_B_INV] = 1'b1;
		ctrl[`STC_B_SOFT] = 1'b1;
		wr_ctrl();
		chk(32'(translator_position), 32'h0000_0000, "soft step new settings");
		ctrl[`STC_B_INV] = 1'b0;
		wr_ctrl();
		chk(32'(translator_position), 32'h0000_0010, "soft step");
		bus(1'b0, 32'(`STC_A_CTRL), 32'h0);
		chk(32'(rd[`STC_B_SOFT]), 32'h0000_0000, "soft bit clear");
		exp_pos = 6'h20;
		pin_step(1'b1);
		ctrl[`STC_B_SOFT] = 1'b0;
		bus(1'b1, 32'(`STC_A_POS), 32'h0000_003F);
		idle(3);
		chk(32'(translator_position), 32'h0000_003F, "position write");
		ctrl[`STC_F_RES] = 3'h0;
		wr_ctrl();
		exp_pos = 6'h00;
		pin_step(1'b1);
		dir_req <= 1'b0;
		idle(30);
		exp_pos = 6'h3F;
		pin_step(1'b1);
		$display("test resolution finished");
	endtask
	task automatic t_uv;
		uv_comp <= 1'b1;
		idle(600);
		chk(32'(fault_out_n_oe), 32'h0000_0001, "fault output");
		chk(32'(bridge_hiz), 32'h0000_0001, "hiz action");
		exp_pos = exp_pos - 6'h01;
		pin_step(1'b1);
		bus(1'b0, 32'(`STC_A_STATUS), 32'h0);
		chk(rd & 32'h0000_0007, 32'h0000_0007, "low supply flags");
		ctrl[`STC_B_UVACT] = 1'b1;
		ctrl[`STC_B_EN] = 1'b1;
		wr_ctrl();
		chk(32'(bridge_brake), 32'h0000_0001, "brake action");
		uv_comp <= 1'b0;
		idle(10);
		bus(1'b0, 32'(`STC_A_STATUS), 32'h0);
		chk(rd & 32'h0000_0040, 32'h0000_0000, "enable refused");
		bus(1'b0, 32'(`STC_A_STATUS), 32'h0);
		chk(rd & 32'h0000_0003, 32'h0000_0000, "flags cleared");
		wr_ctrl();
		chk(32'({bridge_hiz, bridge_brake, fault_out_n_oe}), 32'h0000_0000, "enabled");
		$display("test low supply finished");
	endtask
	task automatic t_sleep_current;
		sleep_mode <= 1'b1;
		dir_req <= 1'b1;
		pin_step(1'b0);
		chk(32'(rotation_up), 32'h0000_0000, "sleep direction");
		sleep_mode <= 1'b0;
		ctrl[`STC_F_PEAK] = 4'hA;
		ctrl[`STC_B_BOOST] = 1'b1;
		wr_ctrl();
		idle(25);
		chk(32'({peak_current_code, boost_applied}), 32'h0000_0015, "peak and boost");
		thermal_warn <= 1'b1;
		idle(25);
		bus(1'b0, 32'(`STC_A_STATUS), 32'h0);
		chk(32'({rd[4], boost_applied}), 32'h0000_0000, "boost dropped");
		thermal_warn <= 1'b0;
		$display("test sleep and current finished");
	endtask
	task automatic t_stall;
		bus(1'b1, 32'(`STC_A_STALL), 32'h00FF_0400);
		zc(5'h1F, 2);
		chk(rd & 32'h0000_003F, 32'h0000_0000, "code before crossing end");
		bus(1'b0, 32'(`STC_A_BEMF), 32'h0);
		chk(rd & 32'h0000_003F, 32'h0000_003F, "code and ready");
		zc(5'h02, 2);
		chk(32'(fault_out_n_oe), 32'h0000_0000, "one low crossing");
		zc(5'h02, 2);
		exp_pos = exp_pos - 6'h18;
		chk(32'(translator_position), 32'(exp_pos), "stall back step");
		chk(32'({fault_out_n_oe, fault_out_n_o}), 32'h0000_0002, "stall error");
		pin_step(1'b0);
		bus(1'b0, 32'(`STC_A_STATUS), 32'h0);
		chk(rd & 32'h0000_0008, 32'h0000_0008, "stall kept");
		dir_req <= 1'b0;
		idle(40);
		bus(1'b0, 32'(`STC_A_STATUS), 32'h0);
		bus(1'b0, 32'(`STC_A_STATUS), 32'h0);
		chk(32'({rd[3], fault_out_n_oe}), 32'h0000_0000, "stall cleared");
		exp_pos = exp_pos - 6'h01;
		pin_step(1'b1);
		bus(1'b1, 32'(`STC_A_STALL), 32'h00FF_0401);
		zc(5'h1D, 120);
		chk(rd & 32'h0000_001F, 32'h0000_001D, "timeout sample");
		bus(1'b1, 32'(`STC_A_STALL), 32'h00FF_0400);
		zc(5'h1B, 120);
		chk(rd & 32'h0000_001F, 32'h0000_001D, "timeout off");
		ctrl[`STC_B_STRM] = 1'b1;
		wr_ctrl();
		zc(5'h19, 2);
		chk(rd & 32'h0000_001F, 32'h0000_0019, "stream sample");
		bus(1'b1, 32'(`STC_A_STALL), 32'h0000_0400);
		zc(5'h17, 2);
		chk(rd & 32'h0000_001F, 32'h0000_0019, "interval gate");
		$display("test stall finished");
	endtask
	initial begin
		reset = 1'b1;
		{hsel, hwrite, uv_comp, thermal_warn, sleep_mode, dir_req, zc_active, bemf_valid} = 8'h00;
		bemf_code = 5'h00;
		haddr = 32'h0;
		hwdata = 32'h0;
		htrans = 2'b00;
		hsize = 3'h2;
		step_req = 8'h00;
		ctrl = 32'h0;
		exp_pos = 6'h08;
		bad_count = 0;
		total_checks = 0;
		cycles = 0;
		idle(12);
		reset <= 1'b0;
		idle(1);
		t_reset();
		t_dir();
		t_res();
		t_uv();
		t_sleep_current();
		t_stall();
		finish_test();
	end
endmodule // test_stepper_translator_stall_control
`default_nettype wire
